// ===== hw/tmcpt_pkg.sv
package tmcpt_pkg;
  // Register bus
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 5;
  localparam int NUM_REGS = 16;
  localparam logic [IDX_W-1:0] IDX_STATUS = 5'h00;
  localparam logic [IDX_W-1:0] IDX_LINE_CONFIG_CONTROL = 5'h10;
  localparam logic [IDX_W-1:0] IDX_TX_PULSE_SHAPE_CONTROL = 5'h11;
  localparam logic [IDX_W-1:0] IDX_UNUSED_SLOT_A = 5'h12;
  localparam logic [IDX_W-1:0] IDX_JITTER_ATTEN_CONTROL = 5'h13;
  localparam logic [IDX_W-1:0] IDX_UNUSED_SLOT_B = 5'h14;
  localparam logic [IDX_W-1:0] IDX_UNUSED_SLOT_C = 5'h15;
  localparam logic [IDX_W-1:0] IDX_EQUALIZER_UPPER_LIMIT = 5'h16;
  localparam logic [IDX_W-1:0] IDX_EQUALIZER_LOWER_LIMIT = 5'h17;
  localparam logic [IDX_W-1:0] IDX_SERIAL_STREAM_CONFIG = 5'h18;
  localparam logic [IDX_W-1:0] IDX_HDLC_ZERO_SLOT_SELECT = 5'h19;
  localparam logic [IDX_W-1:0] IDX_HDLC_ONE_SLOT_SELECT = 5'h1A;
  localparam logic [IDX_W-1:0] IDX_HDLC_TWO_SLOT_SELECT = 5'h1B;
  localparam logic [IDX_W-1:0] IDX_PULSE_PHASE_ONE_COEFF = 5'h1C;
  localparam logic [IDX_W-1:0] IDX_PULSE_PHASE_TWO_COEFF = 5'h1D;
  localparam logic [IDX_W-1:0] IDX_PULSE_PHASE_THREE_COEFF = 5'h1E;
  localparam logic [IDX_W-1:0] IDX_PULSE_PHASE_FOUR_COEFF = 5'h1F;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  // Line configuration word fields
  localparam int CFG_LINE_STANDARD_SELECT = 7;
  localparam int CFG_LINE_DRIVER_ON = 5;
  localparam int CFG_FRONT_END_BYPASS = 4;
  localparam int CFG_SIGNAL_LOSS_THRESHOLD_SEL = 3;
  localparam int CFG_FRAME_PULSE_PIN_FUNCTION = 2;
  localparam int CFG_TEST_SEQUENCE_SOURCE = 1;
  // Status word fields
  localparam int STS_SIGNAL_LOSS = 0;
  localparam int STS_PRBS_ERROR = 1;
  localparam int STS_BYPASS_ACTIVE = 2;
  // Loss-of-signal thresholds, dB below nominal
  localparam logic [7:0] LOS_DB_DEEP = 8'h28;
  localparam logic [7:0] LOS_DB_SHALLOW = 8'h14;
  // A-law digital milliwatt, eight bytes per cycle
  localparam int MW_LEN = 8;
  localparam logic [7:0] MW_SEQ [MW_LEN] = '{8'h34, 8'h21, 8'h21, 8'h34,
                                            8'hB4, 8'hA1, 8'hA1, 8'hB4};
  // Pseudo-random sequence, x^15 + x^14 + 1
  localparam int PRBS_W = 15;
  localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7FFF;
endpackage

// ===== hw/tmcpt_regs.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// RQ1 - Byte addresses 0x40..0x7C decode a five-bit index onto sixteen eight-bit registers 10H..1FH.
// RQ2 - Software writes zero to every bit of the unused registers at 12H, 14H and 15H.
// RQ3 - Bit 7 of the line configuration word selects T1 when 0 and E1 when 1.
// RQ4 - Software keeps the reserved bits 6 and 0 of the line configuration word at zero.
// RQ5 - Bit 5 of the line configuration word switches both line drivers off at 0 and on at 1.
// RQ6 - Bit 4 of the line configuration word keeps the front end active at 0 and bypasses it at 1.
// RQ7 - In bypass, both digital receive inputs are captured on each rising external clock edge.
// RQ8 - In bypass, both digital transmit outputs are launched on each rising external clock edge.
// RQ9 - Bit 3 sets the loss-of-signal threshold to 40 dB below nominal at 0 and 20 dB at 1.
// RQ10 - With bit 2 at 1 the shared pin gives a positive frame pulse aligned to the transmit stream.
// RQ11 - With bit 2 at 0 the shared pin gives a low pulse at the output multiframe boundary.
// RQ12 - With bit 1 at 1 every test channel, transmit or receive, carries the digital milliwatt.
// RQ13 - With bit 1 at 0 transmit test channels get the generator and receive ones the detector.
// RQ14 - Each page register holds the last byte written and returns it on a read without side effects.
module tmcpt_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [tmcpt_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [tmcpt_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [tmcpt_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Configuration levels
  output logic o_line_standard_select,
  output logic o_front_end_enable,
  output logic o_signal_loss_threshold_sel,
  // Line drivers
  input wire logic i_tx_pos_data,
  input wire logic i_tx_neg_data,
  output logic o_tx_line_pos_output,
  output logic o_tx_line_pos_oe,
  output logic o_tx_line_neg_output,
  output logic o_tx_line_neg_oe,
  // Front-end bypass
  input wire logic i_external_line_clock,
  input wire logic i_digital_rx_in_a,
  input wire logic i_digital_rx_in_b,
  output logic o_rx_line_a,
  output logic o_rx_line_b,
  output logic o_rx_line_valid,
  output logic o_digital_tx_out_a,
  output logic o_digital_tx_out_b,
  // Loss of signal
  input wire logic [7:0] i_rx_atten_db,
  output logic o_signal_loss,
  // Frame pulse
  input wire logic i_tx_frame_start,
  input wire logic i_out_multiframe_start,
  output logic o_shared_frame_pulse_pin,
  // Per-timeslot test
  input wire logic i_slot_strobe,
  input wire logic i_per_slot_tx_test,
  input wire logic i_per_slot_rx_test,
  input wire logic [7:0] i_tx_slot_byte,
  input wire logic [7:0] i_rx_slot_byte,
  output logic [7:0] o_tx_slot_byte,
  output logic [7:0] o_rx_slot_byte,
  output logic o_prbs_error
);
  import tmcpt_pkg::*;

  function automatic logic [PRBS_W-1:0] prbs_step8(input logic [PRBS_W-1:0] s);
    logic [PRBS_W-1:0] v;
    v = s;
    for (int k = 0; k < 8; k++) begin
      v = {v[PRBS_W-2:0], v[PRBS_W-1] ^ v[PRBS_W-2]};
    end
    return v;
  endfunction

  function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  logic [REG_W-1:0] regs [NUM_REGS];
  logic ack;
  logic req;
  logic [IDX_W-1:0] idx;
  logic page_hit;
  logic wr_fire;
  logic rd_take;
  logic [REG_W-1:0] cfg;
  logic [REG_W-1:0] status;
  logic prbs_err;
  logic bypass;
  logic [2:0] xclk_sync;
  logic xclk_rise;
  logic [7:0] los_limit;
  logic [2:0] mw_tx_idx;
  logic [2:0] mw_rx_idx;
  logic [PRBS_W-1:0] prbs_gen;
  logic [PRBS_W-1:0] prbs_ref;
  logic [PRBS_W-1:0] next_prbs_gen;
  logic [PRBS_W-1:0] next_prbs_ref;
  logic tx_test_hit;
  logic rx_test_hit;

  // Bus decode: one wait cycle on every access
  assign req = i_avs_read | i_avs_write;
  assign idx = addr_index(i_avs_address);
  assign page_hit = idx[IDX_W-1]; // [RQ1]
  assign o_avs_waitrequest = req & ~ack;
  assign wr_fire = i_avs_write & ack & i_avs_byteenable[0];
  assign rd_take = i_avs_read & ~ack;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Page registers, plain storage, written only through byte lane 0
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        regs[r] <= REG_RESET;
      end
    end else if (wr_fire && page_hit) begin
      regs[idx[IDX_W-2:0]] <= i_avs_writedata[REG_W-1:0]; // [RQ14]
    end
  end

  assign cfg = regs[IDX_LINE_CONFIG_CONTROL[IDX_W-2:0]];

  // Read data captured on the same edge that drops waitrequest; unmapped reads give zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= '0;
    end else if (rd_take) begin
      if (page_hit) begin
        o_avs_readdata <= {24'h000000, regs[idx[IDX_W-2:0]]}; // [RQ14]
      end else if (idx == IDX_STATUS) begin
        o_avs_readdata <= {24'h000000, status};
      end else begin
        o_avs_readdata <= '0;
      end
    end
  end

  // Mode levels taken straight from the configuration word
  assign o_line_standard_select = cfg[CFG_LINE_STANDARD_SELECT]; // [RQ3]
  assign bypass = cfg[CFG_FRONT_END_BYPASS];
  assign o_front_end_enable = ~bypass; // [RQ6]
  assign o_signal_loss_threshold_sel = cfg[CFG_SIGNAL_LOSS_THRESHOLD_SEL];

  // Line drivers
  assign o_tx_line_pos_oe = cfg[CFG_LINE_DRIVER_ON]; // [RQ5]
  assign o_tx_line_neg_oe = cfg[CFG_LINE_DRIVER_ON]; // [RQ5]

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_line_pos_output <= 1'b0;
      o_tx_line_neg_output <= 1'b0;
    end else begin
      o_tx_line_pos_output <= i_tx_pos_data & cfg[CFG_LINE_DRIVER_ON] & ~bypass; // [RQ5]
      o_tx_line_neg_output <= i_tx_neg_data & cfg[CFG_LINE_DRIVER_ON] & ~bypass; // [RQ5]
    end
  end

  // External line clock edge; the clock must be far slower than i_mclk
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      xclk_sync <= 3'h0;
    end else begin
      xclk_sync <= {xclk_sync[1:0], i_external_line_clock};
    end
  end

  assign xclk_rise = xclk_sync[1] & ~xclk_sync[2];

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_line_a <= 1'b0;
      o_rx_line_b <= 1'b0;
      o_rx_line_valid <= 1'b0;
    end else begin
      o_rx_line_valid <= bypass & xclk_rise;
      if (bypass && xclk_rise) begin
        o_rx_line_a <= i_digital_rx_in_a; // [RQ7]
        o_rx_line_b <= i_digital_rx_in_b; // [RQ7]
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_digital_tx_out_a <= 1'b0;
      o_digital_tx_out_b <= 1'b0;
    end else if (!bypass) begin
      o_digital_tx_out_a <= 1'b0;
      o_digital_tx_out_b <= 1'b0;
    end else if (xclk_rise) begin
      o_digital_tx_out_a <= i_tx_pos_data; // [RQ8]
      o_digital_tx_out_b <= i_tx_neg_data; // [RQ8]
    end
  end

  // Loss of signal: attenuation beyond the selected depth
  assign los_limit = cfg[CFG_SIGNAL_LOSS_THRESHOLD_SEL] ? LOS_DB_SHALLOW : LOS_DB_DEEP; // [RQ9]

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_signal_loss <= 1'b0;
    end else begin
      o_signal_loss <= i_rx_atten_db > los_limit; // [RQ9]
    end
  end

  // Shared frame pulse pin
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_shared_frame_pulse_pin <= 1'b1;
    end else if (cfg[CFG_FRAME_PULSE_PIN_FUNCTION]) begin
      o_shared_frame_pulse_pin <= i_tx_frame_start; // [RQ10]
    end else begin
      o_shared_frame_pulse_pin <= ~i_out_multiframe_start; // [RQ11]
    end
  end

  // Per-timeslot test sequences
  assign tx_test_hit = i_slot_strobe & i_per_slot_tx_test;
  assign rx_test_hit = i_slot_strobe & i_per_slot_rx_test;
  assign next_prbs_gen = prbs_step8(prbs_gen);
  assign next_prbs_ref = prbs_step8(prbs_ref);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_slot_byte <= 8'h00;
      mw_tx_idx <= 3'h0;
      prbs_gen <= PRBS_SEED;
    end else if (!i_slot_strobe) begin
      o_tx_slot_byte <= o_tx_slot_byte;
    end else if (!i_per_slot_tx_test) begin
      o_tx_slot_byte <= i_tx_slot_byte;
    end else if (cfg[CFG_TEST_SEQUENCE_SOURCE]) begin
      o_tx_slot_byte <= MW_SEQ[mw_tx_idx]; // [RQ12]
      mw_tx_idx <= mw_tx_idx + 3'h1;
    end else begin
      o_tx_slot_byte <= next_prbs_gen[7:0]; // [RQ13]
      prbs_gen <= next_prbs_gen;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_slot_byte <= 8'h00;
      mw_rx_idx <= 3'h0;
      prbs_ref <= PRBS_SEED;
      o_prbs_error <= 1'b0;
    end else begin
      o_prbs_error <= 1'b0;
      if (rx_test_hit && cfg[CFG_TEST_SEQUENCE_SOURCE]) begin
        o_rx_slot_byte <= MW_SEQ[mw_rx_idx]; // [RQ12]
        mw_rx_idx <= mw_rx_idx + 3'h1;
      end else if (rx_test_hit) begin
        o_rx_slot_byte <= i_rx_slot_byte;
        prbs_ref <= next_prbs_ref;
        o_prbs_error <= i_rx_slot_byte != next_prbs_ref[7:0]; // [RQ13]
      end else if (i_slot_strobe) begin
        o_rx_slot_byte <= i_rx_slot_byte;
      end
    end
  end

  // Status word; sticky error clears on write of one, a new error wins
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      prbs_err <= 1'b0;
    end else if (o_prbs_error) begin
      prbs_err <= 1'b1;
    end else if (wr_fire && idx == IDX_STATUS && i_avs_writedata[STS_PRBS_ERROR]) begin
      prbs_err <= 1'b0;
    end
  end

  always_comb begin
    status = 8'h00;
    status[STS_SIGNAL_LOSS] = o_signal_loss;
    status[STS_PRBS_ERROR] = prbs_err;
    status[STS_BYPASS_ACTIVE] = bypass;
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  logic [IDX_W-2:0] wr_slot;
  logic [REG_W-1:0] wr_byte;
  logic [REG_W-1:0] mw_now;
  logic [REG_W-1:0] mw_rx_now;
  assign wr_slot = idx[IDX_W-2:0];
  assign wr_byte = i_avs_writedata[REG_W-1:0];
  assign mw_now = MW_SEQ[mw_tx_idx];
  assign mw_rx_now = MW_SEQ[mw_rx_idx];

  sequence s_bus_wait;
    req && o_avs_waitrequest;
  endsequence

  sequence s_bus_done;
    !o_avs_waitrequest && ack;
  endsequence

  a_bus_one_wait: assert property ( // [RQ1]
    $rose(req) |-> s_bus_wait ##1 s_bus_done)
    else $error("access did not finish after one wait cycle");

  a_write_then_hold: assert property ( // [RQ14]
    (wr_fire && page_hit) |=> regs[$past(wr_slot)] == $past(wr_byte))
    else $error("page register did not take written byte");

  a_read_returns: assert property ( // [RQ14]
    (rd_take && page_hit) ##1 s_bus_done |-> o_avs_readdata[7:0] == regs[$past(wr_slot)])
    else $error("read did not return stored byte");

  a_std_select: assert property ( // [RQ3]
    (wr_fire && idx == IDX_LINE_CONFIG_CONTROL)
      |=> o_line_standard_select == $past(wr_byte[CFG_LINE_STANDARD_SELECT]))
    else $error("line standard not following configuration");

  // Enables follow the word at once, the registered line data one edge later
  a_driver_off: assert property ( // [RQ5]
    !cfg[CFG_LINE_DRIVER_ON] |-> !o_tx_line_pos_oe && !o_tx_line_neg_oe
      ##1 !o_tx_line_pos_output && !o_tx_line_neg_output)
    else $error("line driver active while switched off");

  a_front_end_gate: assert property ( // [RQ6]
    $rose(cfg[CFG_FRONT_END_BYPASS]) |-> !o_front_end_enable)
    else $error("front end still active in bypass");

  a_bypass_capture: assert property ( // [RQ7]
    (bypass && xclk_rise) |=> o_rx_line_valid && o_rx_line_a == $past(i_digital_rx_in_a))
    else $error("receive bit not captured on external clock");

  a_bypass_launch: assert property ( // [RQ8]
    (bypass && xclk_rise) |=> o_digital_tx_out_b == $past(i_tx_neg_data))
    else $error("transmit bit not launched on external clock");

  a_los_threshold: assert property ( // [RQ9]
    ##1 o_signal_loss == ($past(i_rx_atten_db) > ($past(cfg[3]) ? 8'h14 : 8'h28)))
    else $error("loss of signal threshold wrong");

  a_pulse_positive: assert property ( // [RQ10]
    (cfg[CFG_FRAME_PULSE_PIN_FUNCTION] && i_tx_frame_start) |=> o_shared_frame_pulse_pin)
    else $error("positive frame pulse missing");

  a_pulse_negative: assert property ( // [RQ11]
    (!cfg[CFG_FRAME_PULSE_PIN_FUNCTION] && i_out_multiframe_start) |=> !o_shared_frame_pulse_pin)
    else $error("multiframe low pulse missing");

  a_milliwatt_source: assert property ( // [RQ12]
    (tx_test_hit && cfg[CFG_TEST_SEQUENCE_SOURCE]) |=> o_tx_slot_byte == $past(mw_now))
    else $error("milliwatt byte not applied");

  a_prbs_source: assert property ( // [RQ13]
    (tx_test_hit && !cfg[CFG_TEST_SEQUENCE_SOURCE]) |=> o_tx_slot_byte == prbs_gen[7:0])
    else $error("generator byte not applied");

  a_rx_milliwatt: assert property ( // [RQ12]
    (rx_test_hit && cfg[CFG_TEST_SEQUENCE_SOURCE]) |=> o_rx_slot_byte == $past(mw_rx_now))
    else $error("receive milliwatt byte not applied");

  a_error_sticky: assert property ( // [RQ13]
    o_prbs_error |=> prbs_err)
    else $error("sequence error not held in status");

  a_unmapped_zero: assert property ( // [RQ1]
    (rd_take && !page_hit && idx != IDX_STATUS) |=> o_avs_readdata == '0)
    else $error("unmapped read returned data");
endmodule

// ===== tb/tmcpt_host.sv
`timescale 1ns/100ps
module tmcpt_host (
  // Clock
  input wire logic i_mclk,
  // Avalon-MM master side
  output logic [tmcpt_pkg::ADDR_W-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [tmcpt_pkg::DATA_W-1:0] o_writedata,
  output logic [3:0] o_byteenable,
  input wire logic [tmcpt_pkg::DATA_W-1:0] i_readdata,
  input wire logic i_waitrequest
);
  import tmcpt_pkg::*;
  initial begin
    o_address = '0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = '0;
    o_byteenable = 4'hF;
  end
  // One bus transfer; request held until waitrequest is seen low at an edge
  task automatic xfer(input logic is_wr, input logic [4:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    logic [7:0] v;
    v = d;
    if (idx == IDX_LINE_CONFIG_CONTROL) v = d & 8'hBE;
    if (idx inside {5'h12, 5'h14, 5'h15}) v = 8'h00;
    ok = 1'b0;
    q = 8'h00;
    @(posedge i_mclk);
    o_address <= {idx, 2'b00};
    o_writedata <= {24'h000000, v};
    o_write <= is_wr;
    o_read <= !is_wr;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge i_mclk);
      if (!i_waitrequest) begin
        ok = 1'b1;
        q = i_readdata[7:0];
      end
    end
    o_write <= 1'b0;
    o_read <= 1'b0;
  endtask
endmodule

// ===== tb/trunk_master_control_page_two_test.sv
`timescale 1ns/100ps
module trunk_master_control_page_two_test;
  import tmcpt_pkg::*;
  logic i_mclk, i_rstn, rd, wr, tp, tn, ext, ra, rb, fs, mf, st, tt, rt;
  logic [6:0] adr;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [7:0] att, tbyte, rbyte, q;
  wire logic wq, lstd, fen, los, po, poe, no, noe, rla, rlb, rlv, digital_tx_out_a, digital_tx_out_b, sl, pin, perr;
  wire logic [7:0] otb, orb;
  int mismatches = 0;
  int checks_done = 0;
  logic [20:0] rows [12] = '{{5'h10, 8'hFF, 8'hBE}, {5'h10, 8'h00, 8'h00},
    {5'h11, 8'hA5, 8'hA5}, {5'h12, 8'hFF, 8'h00}, {5'h13, 8'h5A, 8'h5A},
    {5'h14, 8'h77, 8'h00}, {5'h15, 8'h81, 8'h00}, {5'h16, 8'h3C, 8'h3C},
    {5'h19, 8'hC3, 8'hC3}, {5'h1F, 8'h7E, 8'h7E}, {5'h10, 8'hB6, 8'hB6},
    {5'h05, 8'hC3, 8'h00}};
  tmcpt_host host (.i_mclk(i_mclk), .o_address(adr), .o_read(rd), .o_write(wr),
    .o_writedata(wd), .o_byteenable(be), .i_readdata(rdat), .i_waitrequest(wq));
  tmcpt_regs DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .o_line_standard_select(lstd), .o_front_end_enable(fen),
    .o_signal_loss_threshold_sel(los), .i_tx_pos_data(tp), .i_tx_neg_data(tn),
    .o_tx_line_pos_output(po), .o_tx_line_pos_oe(poe), .o_tx_line_neg_output(no),
    .o_tx_line_neg_oe(noe), .i_external_line_clock(ext), .i_digital_rx_in_a(ra),
    .i_digital_rx_in_b(rb), .o_rx_line_a(rla), .o_rx_line_b(rlb), .o_rx_line_valid(rlv),
    .o_digital_tx_out_a(digital_tx_out_a), .o_digital_tx_out_b(digital_tx_out_b), .i_rx_atten_db(att),
    .o_signal_loss(sl), .i_tx_frame_start(fs), .i_out_multiframe_start(mf),
    .o_shared_frame_pulse_pin(pin), .i_slot_strobe(st), .i_per_slot_tx_test(tt),
    .i_per_slot_rx_test(rt), .i_tx_slot_byte(tbyte), .i_rx_slot_byte(rbyte),
    .o_tx_slot_byte(otb), .o_rx_slot_byte(orb), .o_prbs_error(perr));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] idx, input logic [7:0] d);
    bit ok;
    host.xfer(w, idx, d, q, ok);
    if (!ok) begin
      $display("unexpected waitrequest: expected 0, seen 1");
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic slot(input logic t, input logic r, input logic [7:0] tv, input logic [7:0] rv);
    @(posedge i_mclk);
    st <= 1'b1;
    tt <= t;
    rt <= r;
    tbyte <= tv;
    rbyte <= rv;
    @(posedge i_mclk);
    st <= 1'b0;
    #1;
  endtask
  initial begin
    {i_rstn, rd, wr, tp, tn, ext, ra, rb, fs, mf, st, tt, rt} = '0;
    {att, tbyte, rbyte} = '0;
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    #1;
    chk("front end enable", 1, fen);
    chk("frame pin", 1, pin);
    chk("driver enable", 0, poe);
    for (int i = 0; i < 16; i++) begin
      acc(0, 5'h10 + 5'(i), 0);
      chk("reset value", REG_RESET, q);
    end
    foreach (rows[i]) begin
      acc(1, rows[i][20:16], rows[i][15:8]);
      acc(0, rows[i][20:16], 0);
      chk("readback", rows[i][7:0], q);
      if (rows[i][20:16] == 5'h10) begin
        chk("line standard", rows[i][7], lstd);
        chk("front end", !rows[i][4], fen);
        chk("loss select", rows[i][3], los);
        chk("driver enables", {2{rows[i][5]}}, {poe, noe});
      end
    end
    acc(1, 5'h10, 8'h20);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) acc(1, 5'h10, 8'h08);
      @(posedge i_mclk);
      att <= (i < 2 ? 8'd40 : 8'd20) + 8'(i % 2);
      @(posedge i_mclk);
      tp <= 1'b1;
      tn <= 1'b0;
      step(1);
      chk("signal loss", 8'(i % 2), sl);
    end
    acc(1, 5'h10, 8'h20);
    step(2);
    chk("line pos/neg", 2'b10, {po, no});
    acc(1, 5'h10, 8'h00);
    step(2);
    chk("drivers off", 4'h0, {po, poe, no, noe});
    for (int m = 0; m < 2; m++) begin
      acc(1, 5'h10, m ? 8'h30 : 8'h20);
      @(posedge i_mclk);
      {ra, rb, tp, tn, ext} <= 5'b10101;
      checks_done++;
      for (int n = 0; n < 8 && !rlv; n++) step(1);
      if (rlv !== m) begin
        $display("unexpected capture strobe: expected %0d, seen %b", m, rlv);
        mismatches++;
      end
      chk("rx a/b", m ? 2'b10 : 2'b00, {rla, rlb});
      chk("tx a/b", m ? 2'b10 : 2'b00, {digital_tx_out_a, digital_tx_out_b});
      chk("bypassed line", !m, po);
      @(posedge i_mclk);
      ext <= 1'b0;
      step(5);
    end
    for (int m = 0; m < 2; m++) begin
      acc(1, 5'h10, m ? 8'h04 : 8'h00);
      @(posedge i_mclk);
      {fs, mf} <= m ? 2'b10 : 2'b01;
      @(posedge i_mclk);
      {fs, mf} <= 2'b00;
      #1;
      chk("frame pulse", m, pin);
      step(1);
      chk("frame idle", !m, pin);
    end
    acc(1, 5'h10, 8'h02);
    for (int k = 0; k < MW_LEN; k++) begin
      slot(1, 1, 8'h00, 8'h00);
      chk("tx milliwatt", MW_SEQ[k], otb);
      chk("rx milliwatt", MW_SEQ[k], orb);
    end
    slot(0, 0, 8'h5C, 8'hC5);
    chk("slot pass", 8'h5C, otb);
    chk("slot pass", 8'hC5, orb);
    acc(1, 5'h10, 8'h00);
    for (int k = 0; k < 5; k++) begin
      slot(1, 0, 8'h00, 8'h00);
      slot(0, 1, 8'h00, otb ^ 8'(k == 4));
      chk("sequence error", 8'(k == 4), perr);
    end
    acc(0, 5'h00, 0);
    chk("status", 8'h02, q);
    acc(1, 5'h00, 8'h02);
    acc(0, 5'h00, 0);
    chk("status cleared", 8'h00, q);
    acc(1, 5'h10, 8'h24);
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    step(2);
    chk("reset driver enable", 0, poe);
    chk("reset frame pin", 1, pin);
    chk("reset front end", 1, fen);
    @(posedge i_mclk);
    i_rstn <= 1'b1;
    acc(0, 5'h10, 0);
    chk("reset config", REG_RESET, q);
    end_of_test();
  end
  initial begin
    #2ms;
    $display("unexpected run time: expected end, seen limit");
    mismatches++;
    end_of_test();
  end
endmodule
